// ==== shared/usrc_defs.svh ====
/*
  Constants for the UART sleep, low-power, direction-control and multidrop block.
  Assumes it is included by the package and by the design file, by bare name.
*/
`ifndef USRC_DEFS_SVH
`define USRC_DEFS_SVH

// ==========================================================================
// control bit positions
`define USRC_EFR_ENH_BIT       4
`define USRC_EFR_SPECIAL_BIT   5
`define USRC_IER_SLEEP_BIT     4
`define USRC_IER_LSI_BIT       2
`define USRC_EXTRA_FEATURE_CTRL_TWO_NINE_BIT    0
`define USRC_EXTRA_FEATURE_CTRL_TWO_AUTODIR_BIT 4
`define USRC_EXTRA_FEATURE_CTRL_TWO_INVERT_BIT  5
`define USRC_ADVANCED_FEATURE_CTRL_ONE_RXIGN_BIT   4
`define USRC_MCR_RTS_BIT       1
`define USRC_LCR_PAR_HI        5
`define USRC_LCR_PAR_LO        3
`define USRC_LCR_FORCE0        3'h7

// ==========================================================================
// timing
`define USRC_IDLE_CHARS        4
`define USRC_BITS_PER_CHAR     10
`define USRC_IDLE_CNT_W        16

// ==========================================================================
// reset values
`define USRC_DIR_IDLE          1'b1
`define USRC_RX_EN_RST         1'b0

`endif

// ==== shared/usrc_pkg.sv ====
/*
  Types for the UART sleep, low-power, direction-control and multidrop block.
  Assumes usrc_defs.svh is on the include path.
*/
package usrc_pkg;
  `include "usrc_defs.svh"

  // ========================================================================
  // per-channel control bits
  typedef struct packed {
    logic [7:0] enhanced_feature_reg;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] extra_feature_ctrl_two;
    logic [7:0] advanced_feature_ctrl_one;
    logic [7:0] modem_control_reg;
    logic [7:0] line_control_reg;
    logic [7:0] stop_char2;
  } usrc_cfg_t;

  // per-channel status from the surrounding UART
  typedef struct packed {
    logic       tx_fifo_empty;
    logic       tx_shift_empty;
    logic       rx_fifo_empty;
    logic       int_pending;
    logic       tx_write;
    logic       flow_ctl_en;
    logic       flow_rts;
  } usrc_stat_t;

  // one received character with its ninth bit
  typedef struct packed {
    logic       valid;
    logic       ninth;
    logic [7:0] data;
  } usrc_char_t;

  // character forwarded to the receive FIFO
  typedef struct packed {
    logic       push;
    logic       par_err;
    logic [7:0] data;
  } usrc_push_t;

  typedef enum logic [2:0] {
    USRC_RUN   = 3'b001,
    USRC_SLEEP = 3'b010,
    USRC_LOWP  = 3'b100
  } usrc_pwr_t;
endpackage

// ==== rtl/usrc_top.sv ====
/*
  Power control, RS-485 direction control and 9-bit multidrop receive filter
  for a two-channel UART. Assumes the surrounding UART supplies its control
  registers, FIFO/interrupt status, received characters and a baud tick, and
  gates its own UART and baud clocks with the enable outputs of this block.
*/
// Function
// - sleep needs enhanced bit and both sleep enables
// - rx idle four characters unless override set
// - sleep also needs quiet modem, empty fifos
// - sleep stops uart and baud clocks
// - start bit, tx write, modem change wake
// - after wake, re-sleep automatically when conditions return
// - clearing either sleep enable ends sleep
// - low-power input stops clocks until low
// - direction output: modem bit, flow, or transmitter
// - auto mode: low on write, high when done
// - invert bit flips auto direction polarity
// - nine-bit mode: ninth bit marks address
// - disabled receiver drops data until address
// - address sets parity error, stored in fifo
// - enabled receiver keeps data, flags new addresses
// - special detect matches addresses, discards others
// - match auto-enables receiver, parity in error flag
// - mismatch while auto-enabled disables and discards
`timescale 1ns/10ps
`include "usrc_defs.svh"

module usrc_top
  import usrc_pkg::*;
(
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST,
  input  wire usrc_pkg::usrc_cfg_t  CFG_A,
  input  wire usrc_pkg::usrc_cfg_t  CFG_B,
  input  wire usrc_pkg::usrc_stat_t STAT_A,
  input  wire usrc_pkg::usrc_stat_t STAT_B,
  input  wire usrc_pkg::usrc_char_t RX_CHAR_A,
  input  wire usrc_pkg::usrc_char_t RX_CHAR_B,
  input  wire logic                 RX_EN_SET_A,
  input  wire logic                 RX_EN_SET_B,
  input  wire logic                 RX_EN_CLR_A,
  input  wire logic                 RX_EN_CLR_B,
  input  wire logic                 BAUD_TICK,
  input  wire logic                 SERIAL_IN_CHAN_A,
  input  wire logic                 SERIAL_IN_CHAN_B,
  input  wire logic [3:0]           MODEM_IN_A,
  input  wire logic [3:0]           MODEM_IN_B,
  input  wire logic                 LOW_POWER_INPUT,
  output logic                      UART_CLK_EN,
  output logic                      BAUD_CLK_EN,
  output logic                      HOST_ISOLATE,
  output logic                      SLEEPING,
  output logic                      DIRECTION_CONTROL_OUT_A,
  output logic                      DIRECTION_CONTROL_OUT_B,
  output usrc_pkg::usrc_push_t      RX_PUSH_A,
  output usrc_pkg::usrc_push_t      RX_PUSH_B,
  output logic                      LINE_INT_A,
  output logic                      LINE_INT_B,
  output logic                      RX_ENABLED_A,
  output logic                      RX_ENABLED_B
);
  import usrc_pkg::*;

  localparam int IDLE_BITS = `USRC_IDLE_CHARS * `USRC_BITS_PER_CHAR;

  // ========================================================================
  // state
  typedef struct packed {
    logic [2:0]  sa;
    logic [2:0]  sb;
    logic [2:0]  sl;
    logic [3:0]  ma1;
    logic [3:0]  ma2;
    logic [3:0]  mb1;
    logic [3:0]  mb2;
    logic [3:0]  ma_prev;
    logic [3:0]  mb_prev;
    logic        ma_stable;
    logic        mb_stable;
    logic        rxa_prev;
    logic        rxb_prev;
    logic [`USRC_IDLE_CNT_W-1:0] idle_a;
    logic [`USRC_IDLE_CNT_W-1:0] idle_b;
    usrc_pwr_t   pwr;
    logic        clk_en;
    logic        isolate;
    logic        dir_a;
    logic        dir_b;
    logic        busy_a;
    logic        busy_b;
    logic        rxen_a;
    logic        rxen_b;
    usrc_push_t  push_a;
    usrc_push_t  push_b;
    logic        lint_a;
    logic        lint_b;
  } usrc_state_t;

  usrc_state_t s_q;
  usrc_state_t s_d;

  // ========================================================================
  // per-channel helpers
  function automatic logic sleep_en(input usrc_cfg_t c);
    sleep_en = c.enhanced_feature_reg[`USRC_EFR_ENH_BIT] & c.interrupt_enable_reg[`USRC_IER_SLEEP_BIT];
  endfunction

  // direction output for one channel; busy is data pending in transmitter
  function automatic logic dir_out(input usrc_cfg_t c, input usrc_stat_t st,
                                   input logic busy);
    logic lvl;
    lvl = 1'b0;
    if (c.extra_feature_ctrl_two[`USRC_EXTRA_FEATURE_CTRL_TWO_AUTODIR_BIT]) begin
      lvl = busy ? 1'b0 : 1'b1;
      if (c.extra_feature_ctrl_two[`USRC_EXTRA_FEATURE_CTRL_TWO_INVERT_BIT]) begin
        lvl = ~lvl;
      end
    end else if (st.flow_ctl_en) begin
      lvl = st.flow_rts;
    end else begin
      lvl = ~c.modem_control_reg[`USRC_MCR_RTS_BIT];
    end
    dir_out = lvl;
  endfunction

  // multidrop filter: returns {rx_enable, push, parity_err, line_int}
  function automatic logic [3:0] md_filter(input usrc_cfg_t c, input usrc_char_t ch,
                                           input logic rxen);
    logic nine;
    logic spec;
    logic force0;
    logic en;
    logic push;
    logic perr;
    logic lint;
    nine   = c.extra_feature_ctrl_two[`USRC_EXTRA_FEATURE_CTRL_TWO_NINE_BIT];
    spec   = c.enhanced_feature_reg[`USRC_EFR_SPECIAL_BIT];
    force0 = c.line_control_reg[`USRC_LCR_PAR_HI:`USRC_LCR_PAR_LO] == `USRC_LCR_FORCE0;
    en     = rxen;
    push   = 1'b0;
    perr   = 1'b0;
    lint   = 1'b0;
    if (ch.valid) begin
      if (!nine) begin
        push = rxen;
      end else if (spec) begin
        if (ch.ninth) begin
          if (ch.data == c.stop_char2) begin
            en   = 1'b1;
            push = 1'b1;
            perr = 1'b1;
            lint = c.interrupt_enable_reg[`USRC_IER_LSI_BIT];
          end else begin
            en = 1'b0;
          end
        end else begin
          push = rxen;
        end
      end else begin
        if (ch.ninth && force0) begin
          push = 1'b1;
          perr = 1'b1;
          lint = c.interrupt_enable_reg[`USRC_IER_LSI_BIT];
        end else begin
          push = rxen;
        end
      end
    end
    md_filter = {en, push, perr, lint};
  endfunction

  // ========================================================================
  // next state
  logic sleep_allowed;
  logic wake_evt;
  logic cond_a;
  logic cond_b;
  logic [3:0] fa;
  logic [3:0] fb;

  always_comb begin
    s_d = s_q;
    // three-stage pin sampling; a serial or low-power change counts once stages two and three agree, a modem change as soon as they differ
    s_d.sa = {s_q.sa[1:0], SERIAL_IN_CHAN_A};
    s_d.sb = {s_q.sb[1:0], SERIAL_IN_CHAN_B};
    s_d.sl = {s_q.sl[1:0], LOW_POWER_INPUT};
    s_d.ma1 = MODEM_IN_A;
    s_d.ma2 = s_q.ma1;
    s_d.ma_prev = s_q.ma2;
    s_d.mb1 = MODEM_IN_B;
    s_d.mb2 = s_q.mb1;
    s_d.mb_prev = s_q.mb2;
    s_d.ma_stable = (s_q.ma2 == s_q.ma_prev);
    s_d.mb_stable = (s_q.mb2 == s_q.mb_prev);
    if (s_q.sa[2] == s_q.sa[1]) begin
      s_d.rxa_prev = s_q.sa[2];
    end
    if (s_q.sb[2] == s_q.sb[1]) begin
      s_d.rxb_prev = s_q.sb[2];
    end

    // idle counters run on baud ticks while the line is high
    if (s_d.rxa_prev == 1'b0) begin
      s_d.idle_a = '0;
    end else if (BAUD_TICK && s_q.idle_a < IDLE_BITS[`USRC_IDLE_CNT_W-1:0]) begin
      s_d.idle_a = s_q.idle_a + 1'b1;
    end
    if (s_d.rxb_prev == 1'b0) begin
      s_d.idle_b = '0;
    end else if (BAUD_TICK && s_q.idle_b < IDLE_BITS[`USRC_IDLE_CNT_W-1:0]) begin
      s_d.idle_b = s_q.idle_b + 1'b1;
    end

    cond_a = STAT_A.tx_fifo_empty & STAT_A.tx_shift_empty & STAT_A.rx_fifo_empty
           & ~STAT_A.int_pending & s_q.ma_stable
           & (CFG_A.advanced_feature_ctrl_one[`USRC_ADVANCED_FEATURE_CTRL_ONE_RXIGN_BIT]
              | (s_q.idle_a == IDLE_BITS[`USRC_IDLE_CNT_W-1:0]));
    cond_b = STAT_B.tx_fifo_empty & STAT_B.tx_shift_empty & STAT_B.rx_fifo_empty
           & ~STAT_B.int_pending & s_q.mb_stable
           & (CFG_B.advanced_feature_ctrl_one[`USRC_ADVANCED_FEATURE_CTRL_ONE_RXIGN_BIT]
              | (s_q.idle_b == IDLE_BITS[`USRC_IDLE_CNT_W-1:0]));
    sleep_allowed = sleep_en(CFG_A) & sleep_en(CFG_B);

    // start bit is a falling edge on the agreed line level
    wake_evt = (s_q.rxa_prev & (s_q.sa[2] == s_q.sa[1]) & ~s_q.sa[2])
             | (s_q.rxb_prev & (s_q.sb[2] == s_q.sb[1]) & ~s_q.sb[2])
             | STAT_A.tx_write | STAT_B.tx_write
             | (s_q.ma2 != s_q.ma_prev) | (s_q.mb2 != s_q.mb_prev);

    unique case (s_q.pwr)
      USRC_RUN: begin
        if (sleep_allowed && cond_a && cond_b && !wake_evt) begin
          s_d.pwr = USRC_SLEEP;
        end
      end
      USRC_SLEEP: begin
        if (!sleep_allowed || wake_evt) begin
          s_d.pwr = USRC_RUN;
        end
      end
      USRC_LOWP: begin
        s_d.pwr = USRC_RUN;
      end
      default: begin
        s_d.pwr = USRC_RUN;
      end
    endcase
    // low-power pin overrides everything; agreement of stages two and three
    if (s_q.sl[2] == s_q.sl[1]) begin
      if (s_q.sl[2]) begin
        s_d.pwr = USRC_LOWP;
      end else if (s_q.pwr == USRC_LOWP) begin
        s_d.pwr = USRC_RUN;
      end
    end else if (s_q.pwr == USRC_LOWP) begin
      s_d.pwr = USRC_LOWP;
    end
    s_d.clk_en  = (s_d.pwr == USRC_RUN);
    s_d.isolate = (s_d.pwr == USRC_LOWP);

    // transmitter busy from fifo write until last bit shifted out
    if (STAT_A.tx_write) begin
      s_d.busy_a = 1'b1;
    end else if (STAT_A.tx_fifo_empty && STAT_A.tx_shift_empty) begin
      s_d.busy_a = 1'b0;
    end
    if (STAT_B.tx_write) begin
      s_d.busy_b = 1'b1;
    end else if (STAT_B.tx_fifo_empty && STAT_B.tx_shift_empty) begin
      s_d.busy_b = 1'b0;
    end
    s_d.dir_a = dir_out(CFG_A, STAT_A, s_d.busy_a);
    s_d.dir_b = dir_out(CFG_B, STAT_B, s_d.busy_b);

    // receiver enable: software set/clear, then filter's automatic change
    fa = md_filter(CFG_A, RX_CHAR_A, s_q.rxen_a);
    fb = md_filter(CFG_B, RX_CHAR_B, s_q.rxen_b);
    s_d.rxen_a = fa[3];
    s_d.rxen_b = fb[3];
    // an automatic change in the same cycle beats the controller's write
    if (!RX_CHAR_A.valid || fa[3] == s_q.rxen_a) begin
      if (RX_EN_SET_A) begin
        s_d.rxen_a = 1'b1;
      end else if (RX_EN_CLR_A) begin
        s_d.rxen_a = 1'b0;
      end
    end
    if (!RX_CHAR_B.valid || fb[3] == s_q.rxen_b) begin
      if (RX_EN_SET_B) begin
        s_d.rxen_b = 1'b1;
      end else if (RX_EN_CLR_B) begin
        s_d.rxen_b = 1'b0;
      end
    end
    s_d.push_a = '{push: fa[2], par_err: fa[1], data: RX_CHAR_A.data};
    s_d.push_b = '{push: fb[2], par_err: fb[1], data: RX_CHAR_B.data};
    s_d.lint_a = fa[0];
    s_d.lint_b = fb[0];
  end

  // ========================================================================
  // registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_q         <= '0;
      s_q.sa      <= 3'h7;
      s_q.sb      <= 3'h7;
      s_q.rxa_prev <= 1'b1;
      s_q.rxb_prev <= 1'b1;
      s_q.pwr     <= USRC_RUN;
      s_q.clk_en  <= 1'b1;
      s_q.dir_a   <= `USRC_DIR_IDLE;
      s_q.dir_b   <= `USRC_DIR_IDLE;
      s_q.rxen_a  <= `USRC_RX_EN_RST;
      s_q.rxen_b  <= `USRC_RX_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // outputs, all straight from flip-flops
  assign UART_CLK_EN             = s_q.clk_en;
  assign BAUD_CLK_EN             = s_q.clk_en;
  assign HOST_ISOLATE            = s_q.isolate;
  assign SLEEPING                = s_q.pwr[1];
  assign DIRECTION_CONTROL_OUT_A = s_q.dir_a;
  assign DIRECTION_CONTROL_OUT_B = s_q.dir_b;
  assign RX_PUSH_A               = s_q.push_a;
  assign RX_PUSH_B               = s_q.push_b;
  assign LINE_INT_A              = s_q.lint_a;
  assign LINE_INT_B              = s_q.lint_b;
  assign RX_ENABLED_A            = s_q.rxen_a;
  assign RX_ENABLED_B            = s_q.rxen_b;

endmodule

// ==== verif/usrc_station.sv ====
/*
  Remote multidrop station seen from one receiver: drives the serial line and
  hands over each decoded character for one cycle.
  Assumes the bench calls send() just after a rising edge of clk.
*/
`timescale 1ns/10ps
module usrc_station
  import usrc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            brk,
  output logic                 ser,
  output usrc_pkg::usrc_char_t chr
);
  logic line;

  // a held break pulls the idle-high line low
  assign ser = line & ~brk;

  initial begin
    line = 1'b1;
    chr = '0;
  end

  // ==========================================================================
  // one character: start bit, then the decoded byte with its ninth bit
  task automatic send(input logic nb, input logic [7:0] d);
    @(posedge clk);
    #2 line = 1'b0;
    @(posedge clk);
    #2 chr = {1'b1, nb, d};
    @(posedge clk);
    // stale fields are inverted so nothing can rely on them after the pulse
    #2 chr = {1'b0, ~nb, ~d};
    line = 1'b1;
  endtask
endmodule

// ==== verif/usrc_assertions.sv ====
/*
  Concurrent checks on power, direction and multidrop behaviour of channel A.
  Assumes it is bound to usrc_top, whose ports it matches by name.
*/
`timescale 1ns/10ps
module usrc_chk
  import usrc_pkg::*;
(
  input wire logic                 SYS_CLK,
  input wire logic                 RST,
  input wire usrc_pkg::usrc_cfg_t  CFG_A,
  input wire usrc_pkg::usrc_cfg_t  CFG_B,
  input wire usrc_pkg::usrc_stat_t STAT_A,
  input wire usrc_pkg::usrc_char_t RX_CHAR_A,
  input wire logic                 RX_EN_SET_A,
  input wire logic                 LOW_POWER_INPUT,
  input wire logic                 UART_CLK_EN,
  input wire logic                 BAUD_CLK_EN,
  input wire logic                 HOST_ISOLATE,
  input wire logic                 SLEEPING,
  input wire logic                 DIRECTION_CONTROL_OUT_A,
  input wire usrc_pkg::usrc_push_t RX_PUSH_A,
  input wire logic                 LINE_INT_A,
  input wire logic                 RX_ENABLED_A
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // ==========================================================================
  // sequences
  sequence s_nine;
    RX_CHAR_A.valid && RX_CHAR_A.ninth && CFG_A.extra_feature_ctrl_two[0];
  endsequence
  sequence s_match;
    s_nine ##0 (CFG_A.enhanced_feature_reg[5] && RX_CHAR_A.data == CFG_A.stop_char2);
  endsequence
  sequence s_miss;
    s_nine ##0 (CFG_A.enhanced_feature_reg[5] && RX_CHAR_A.data != CFG_A.stop_char2);
  endsequence
  sequence s_norm;
    s_nine ##0 (!CFG_A.enhanced_feature_reg[5] && CFG_A.line_control_reg[5:3] == 3'h7);
  endsequence
  sequence s_flag;
    RX_PUSH_A.push && RX_PUSH_A.par_err && LINE_INT_A == $past(CFG_A.interrupt_enable_reg[2]);
  endsequence
  // low-power input quiet long enough that its synchroniser cannot interfere
  sequence s_wr;
    (!LOW_POWER_INPUT)[*4] ##0 (SLEEPING && STAT_A.tx_write);
  endsequence

  // ==========================================================================
  // power
  sleep_clk_off_a: assert property (SLEEPING |-> !UART_CLK_EN && !BAUD_CLK_EN)
    else $error("clocks run while sleeping");
  sleep_enable_a: assert property (
    !(CFG_A.enhanced_feature_reg[4] && CFG_A.interrupt_enable_reg[4] && CFG_B.interrupt_enable_reg[4]) |=> !SLEEPING)
    else $error("sleeping while not enabled");
  busy_no_sleep_a: assert property (
    !SLEEPING && (STAT_A.int_pending || !STAT_A.rx_fifo_empty) |=> !SLEEPING)
    else $error("slept while busy");
  tx_wake_a: assert property (s_wr |=> !SLEEPING && UART_CLK_EN)
    else $error("transmit write did not wake");
  lowp_stop_a: assert property (
    LOW_POWER_INPUT[*8] |-> HOST_ISOLATE && !UART_CLK_EN && !BAUD_CLK_EN)
    else $error("low power not entered");
  lowp_release_a: assert property ((!LOW_POWER_INPUT)[*8] |-> !HOST_ISOLATE)
    else $error("isolation kept after release");

  // ==========================================================================
  // direction control
  dir_write_a: assert property (
    CFG_A.extra_feature_ctrl_two[4] && STAT_A.tx_write |=>
    DIRECTION_CONTROL_OUT_A == $past(CFG_A.extra_feature_ctrl_two[5]))
    else $error("direction not turned on write");
  dir_done_a: assert property (
    CFG_A.extra_feature_ctrl_two[4] && !STAT_A.tx_write && STAT_A.tx_fifo_empty && STAT_A.tx_shift_empty
    |=> DIRECTION_CONTROL_OUT_A == !$past(CFG_A.extra_feature_ctrl_two[5]))
    else $error("direction not released when empty");
  dir_modem_a: assert property (
    !CFG_A.extra_feature_ctrl_two[4] && !STAT_A.flow_ctl_en |=> DIRECTION_CONTROL_OUT_A == !$past(CFG_A.modem_control_reg[1]))
    else $error("direction not from modem bit");
  dir_flow_a: assert property (
    !CFG_A.extra_feature_ctrl_two[4] && STAT_A.flow_ctl_en |=> DIRECTION_CONTROL_OUT_A == $past(STAT_A.flow_rts))
    else $error("direction not from flow control");

  // ==========================================================================
  // multidrop receive
  addr_norm_a: assert property (s_norm |=> s_flag)
    else $error("address not flagged");
  addr_match_a: assert property (s_match |=> s_flag ##0 RX_ENABLED_A)
    else $error("matching address not taken");
  addr_miss_a: assert property (s_miss |=> !RX_PUSH_A.push && !RX_ENABLED_A)
    else $error("foreign address not dropped");
  data_drop_a: assert property (
    RX_CHAR_A.valid && !RX_CHAR_A.ninth && CFG_A.extra_feature_ctrl_two[0] && !RX_ENABLED_A && !RX_EN_SET_A
    |=> !RX_PUSH_A.push)
    else $error("data stored while disabled");
endmodule

bind usrc_top usrc_chk chk (.*);

// ==== verif/uart_sleep_rs485_control_tb.sv ====
/*
  Self-checking bench for usrc_top: direction control, multidrop filter, sleep.
  Assumes usrc_station as the remote side and the checker bound beside the design.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module uart_sleep_rs485_control_tb;
  import usrc_pkg::*;
  logic        clk, rst, bt, lp, brk, set_a, clr_a, ser_a, ser_b;
  logic        sleeping, uclk, bclk, iso, dir_a, dir_b, lint_a, en_a;
  logic        brk_b, lint_b, en_b;
  logic [3:0]  mdm;
  logic [31:0] r;
  logic [31:0] rs = 32'h84C8;
  usrc_cfg_t   ca, cb;
  usrc_stat_t  sa, sb;
  usrc_char_t  ch_a;
  usrc_push_t  push_a, push_b;
  int          failures, n_tests;

  usrc_top dut (.SYS_CLK(clk), .RST(rst), .CFG_A(ca), .CFG_B(cb), .STAT_A(sa), .STAT_B(sb),
    .RX_CHAR_A(ch_a), .RX_CHAR_B(ch_a), .RX_EN_SET_A(set_a), .RX_EN_SET_B(set_a),
    .RX_EN_CLR_A(clr_a), .RX_EN_CLR_B(clr_a), .BAUD_TICK(bt), .SERIAL_IN_CHAN_A(ser_a),
    .SERIAL_IN_CHAN_B(ser_b), .MODEM_IN_A(mdm), .MODEM_IN_B(mdm), .LOW_POWER_INPUT(lp),
    .UART_CLK_EN(uclk), .BAUD_CLK_EN(bclk), .HOST_ISOLATE(iso), .SLEEPING(sleeping),
    .DIRECTION_CONTROL_OUT_A(dir_a), .DIRECTION_CONTROL_OUT_B(dir_b), .RX_PUSH_A(push_a),
    .RX_PUSH_B(push_b), .LINE_INT_A(lint_a), .LINE_INT_B(lint_b), .RX_ENABLED_A(en_a),
    .RX_ENABLED_B(en_b));
  usrc_station st_a (.clk(clk), .brk(brk), .ser(ser_a), .chr(ch_a));
  // channel B's filter sees channel A's characters; its station only drives the pin
  usrc_station st_b (.clk(clk), .brk(brk_b), .ser(ser_b), .chr());

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // a baud tick every other cycle keeps the idle count short
  always @(posedge clk) bt <= #2 ~bt;

  // ==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // r: auto, invert, modem bit, flow enable, flow level, write
  function automatic logic exp_dir(logic [7:0] v);
    if (v[0]) return v[5] ? v[1] : !v[1];
    return v[3] ? v[4] : !v[2];
  endfunction
  task automatic stop_test();
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded wait for a sleep state; running out ends the run
  task automatic waitv(input logic v, input int n);
    while (sleeping !== v && n > 0) begin
      @(posedge clk);
      #2 n--;
    end
    `CHK(sleeping, v)
    if (sleeping !== v) stop_test();
  endtask
  task automatic en_pulse(input logic s);
    set_a = s;
    clr_a = ~s;
    @(posedge clk);
    #2 set_a = 1'b0;
    clr_a = 1'b0;
  endtask
  // e: pushed, flagged, receiver enabled afterwards
  task automatic md(input logic nb, input logic [7:0] d, input logic [2:0] e);
    st_a.send(nb, d);
    `CHK({push_a.push, push_a.par_err & push_a.push, lint_a, en_a}, {e[2:1], e[1:0]})
    `CHK({push_b.push, push_b.par_err & push_b.push, lint_b, en_b}, {e[2:1], e[1:0]})
    if (e[2]) `CHK(push_a.data, d)
    if (e[2]) `CHK(push_b.data, d)
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    bt = 1'b0;
    lp = 1'b0;
    brk = 1'b0;
    brk_b = 1'b0;
    set_a = 1'b0;
    clr_a = 1'b0;
    mdm = 4'h0;
    ca = '0;
    cb = '0;
    sa = 7'h70;
    sb = 7'h70;
    repeat (16) @(posedge clk);
    #2 rst = 1'b0;
    @(posedge clk);
    #2 `CHK({sleeping, dir_a}, 2'b01)
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      ca.extra_feature_ctrl_two[4] = r[0];
      ca.extra_feature_ctrl_two[5] = r[1];
      ca.modem_control_reg[1] = r[2];
      sa.flow_ctl_en = r[3] & ~r[0];
      sa.flow_rts = r[4];
      sa.tx_write = r[5];
      sa.tx_fifo_empty = ~r[5] | r[6];
      sa.tx_shift_empty = ~r[5] | r[6];
      cb = ca;
      sb = sa;
      @(posedge clk);
      #2 `CHK(dir_a, exp_dir(r[7:0]))
      `CHK(dir_b, exp_dir(r[7:0]))
    end
    sa = 7'h70;
    sb = 7'h70;
    ca = '0;
    ca.interrupt_enable_reg[2] = 1'b1;
    cb = ca;
    md(1'b1, 8'h96, 3'b000);
    ca.extra_feature_ctrl_two[0] = 1'b1;
    ca.line_control_reg[5:3] = 3'h7;
    cb = ca;
    md(1'b0, 8'hC3, 3'b000);
    md(1'b1, 8'h3C, 3'b110);
    en_pulse(1'b1);
    md(1'b0, 8'hA5, 3'b101);
    md(1'b1, 8'h5A, 3'b111);
    en_pulse(1'b0);
    md(1'b0, 8'h01, 3'b000);
    // without forced parity 0 an address is only ordinary data
    ca.line_control_reg[5:3] = 3'h6;
    cb = ca;
    md(1'b1, 8'h69, 3'b000);
    r = rnd();
    ca.enhanced_feature_reg[5] = 1'b1;
    ca.stop_char2 = r[7:0];
    cb = ca;
    md(1'b0, r[7:0], 3'b000);
    md(1'b1, r[7:0] ^ 8'h01, 3'b000);
    md(1'b1, r[7:0], 3'b111);
    md(1'b0, r[15:8], 3'b101);
    md(1'b1, r[7:0], 3'b111);
    md(1'b1, r[7:0] ^ 8'h80, 3'b000);
    md(1'b0, r[15:8], 3'b000);
    ca = '0;
    ca.enhanced_feature_reg[4] = 1'b1;
    ca.interrupt_enable_reg[4] = 1'b1;
    cb = ca;
    brk = 1'b1;
    repeat (150) @(posedge clk);
    #2 `CHK(sleeping, 1'b0)
    brk = 1'b0;
    sa.int_pending = 1'b1;
    ca.advanced_feature_ctrl_one[4] = 1'b1;
    cb = ca;
    repeat (30) @(posedge clk);
    #2 `CHK(sleeping, 1'b0)
    sa.int_pending = 1'b0;
    waitv(1'b1, 20);
    `CHK({uclk, bclk}, 2'b00)
    sa.tx_write = 1'b1;
    @(posedge clk);
    #2 sa.tx_write = 1'b0;
    `CHK({sleeping, uclk}, 2'b01)
    waitv(1'b1, 20);
    mdm = 4'h9;
    waitv(1'b0, 8);
    waitv(1'b1, 20);
    brk = 1'b1;
    waitv(1'b0, 8);
    brk = 1'b0;
    waitv(1'b1, 20);
    brk_b = 1'b1;
    waitv(1'b0, 8);
    brk_b = 1'b0;
    waitv(1'b1, 20);
    lp = 1'b1;
    repeat (9) @(posedge clk);
    #2 `CHK({iso, uclk, bclk}, 3'b100)
    lp = 1'b0;
    repeat (9) @(posedge clk);
    #2 `CHK(iso, 1'b0)
    waitv(1'b1, 20);
    // the sleep enable goes first, so any divisor write would land awake
    cb.interrupt_enable_reg[4] = 1'b0;
    @(posedge clk);
    #2 `CHK(sleeping, 1'b0)
    repeat (30) @(posedge clk);
    #2 `CHK(sleeping, 1'b0)
    stop_test();
  end
endmodule
